// ===== bench/sec_front_monitor.sv
// sec_front_monitor: port-level checks for sec_front
// assumes one core_clk domain and pins synced in two cycles
`timescale 1ns/10ps
module sec_front_monitor
	import sec_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic pause_n,
	input wire logic wprot_n,
	input wire logic miso_o,
	input wire logic miso_oe_n,
	input wire logic write_done,
	input wire logic write_refused,
	input wire logic wr_start,
	input wire sec_cmd_t cmd_o,
	input wire logic [7:0] wr_data_o,
	input wire logic [7:0] status_o,
	input wire logic [1:0] protect_size_o,
	input wire logic hard_lock_mode
);
	// ----
	// checks
	// ----
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);
	a_desel_float: assert property (sel_n [*6] |-> miso_oe_n)
		else $error("output driven while deselected");
	a_pause_float: assert property ((!pause_n && !sclk) [*6] |-> miso_oe_n)
		else $error("output driven while paused");
	a_start_desel: assert property (wr_start |-> sel_n && $past(sel_n, 3))
		else $error("write start without deselect");
	a_start_armed: assert property (wr_start |-> $past(status_o[1]))
		else $error("write start with latch clear");
	a_busy_start: assert property (wr_start |-> ##[1:3] status_o[0])
		else $error("busy not raised");
	a_done_clear: assert property (write_done && status_o[0] |-> ##[1:3] status_o[1:0] == 2'h0)
		else $error("busy or latch not cleared");
	a_arm_rise: assert property ($rose(status_o[1]) |-> sel_n)
		else $error("latch set while selected");
	a_zero_bits: assert property (status_o[6:4] == 3'h0)
		else $error("status bits six to four set");
	a_protect_view: assert property (protect_size_o == status_o[3:2])
		else $error("protect bits mismatch");
	a_lock_on: assert property ((!wprot_n && status_o[7]) [*6] |-> hard_lock_mode)
		else $error("hard lock not entered");
	a_lock_off: assert property (wprot_n [*6] |-> !hard_lock_mode)
		else $error("hard lock with pin high");
	a_stat_lock: assert property (wr_start && cmd_o.stat_write |-> !hard_lock_mode)
		else $error("status write under hard lock");
	a_mem_range: assert property (wr_start && cmd_o.mem_write |-> protect_size_o == 2'h0
		|| (protect_size_o == 2'h1 && cmd_o.addr[14:0] < 15'h6000)
		|| (protect_size_o == 2'h2 && cmd_o.addr[14:0] < 15'h4000))
		else $error("write into protected range");
endmodule

bind sec_front sec_front_monitor u_sec_front_monitor (.core_clk(core_clk), .reset(reset), .sel_n(sel_n),
	.sclk(sclk), .mosi(mosi), .pause_n(pause_n), .wprot_n(wprot_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
	.write_done(write_done), .write_refused(write_refused), .wr_start(wr_start), .cmd_o(cmd_o),
	.wr_data_o(wr_data_o), .status_o(status_o), .protect_size_o(protect_size_o), .hard_lock_mode(hard_lock_mode));

// ===== bench/sec_front_tb.sv
// sec_front_tb: self-checking bench for the spi command front end
// assumes the bench plays the write engine through write_done
`timescale 1ns/10ps
module sec_front_tb
	import sec_pkg::*;
;
	// ----
	// harness
	// ----
	logic core_clk, reset, wprot_n, write_done, write_refused;
	logic sel_n, sclk, mosi, pause_n, miso_o, miso_oe_n, wr_start, hard_lock_mode;
	sec_cmd_t cmd_o, last_cmd;
	logic [7:0] wr_data_o, status_o, rx;
	logic [1:0] protect_size_o;
	int fail_count, compares, starts, s;
	// a released line reads inverted so a stale bit cannot pass
	wire logic miso = miso_oe_n ? ~miso_o : miso_o;
	sec_front u_sec_front (.core_clk(core_clk), .reset(reset), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
		.pause_n(pause_n), .wprot_n(wprot_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .write_done(write_done),
		.write_refused(write_refused), .wr_start(wr_start), .cmd_o(cmd_o), .wr_data_o(wr_data_o), .status_o(status_o),
		.protect_size_o(protect_size_o), .hard_lock_mode(hard_lock_mode));
	sec_host_model u_sec_host_model (.core_clk(core_clk), .miso(miso), .sel_n(sel_n), .sclk(sclk),
		.mosi(mosi), .pause_n(pause_n));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (wr_start === 1'b1) begin
			starts++;
			last_cmd <= cmd_o;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic op(input logic [31:0] d, input int n);
		u_sec_host_model.sel();
		u_sec_host_model.shift(d, n, rx);
		u_sec_host_model.desel();
	endtask
	task automatic status_read_instruction(input logic [7:0] exp);
		u_sec_host_model.sel();
		u_sec_host_model.shift(32'(SEC_OP_STAT_RD), 8, rx);
		repeat (2) begin
			u_sec_host_model.shift(32'h0, 8, rx);
			chk(rx, exp);
		end
		u_sec_host_model.desel();
	endtask
	task automatic done();
		write_done = 1'b1;
		u_sec_host_model.tick(1);
		write_done = 1'b0;
		u_sec_host_model.tick(4);
	endtask
	task automatic wstat(input logic [7:0] v);
		op(32'(SEC_OP_ARM), 8);
		op({16'h0, SEC_OP_STAT_WR, v}, 16);
		done();
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_arm();
		op(32'h0C, 9);
		chk(status_o, 8'h00);
		op(32'(SEC_OP_ARM), 8);
		chk(status_o, 8'h02);
		status_read_instruction(8'h02);
		op(32'(SEC_OP_DISARM), 8);
		chk(status_o, 8'h00);
		s = starts;
		op({SEC_OP_ARR_WR, 24'h0000A5}, 32);
		chk(starts - s, 0);
	endtask
	task automatic t_stat_write();
		s = starts;
		op(32'(SEC_OP_ARM), 8);
		op({17'h0, SEC_OP_STAT_WR, 7'h7F}, 15);
		chk(starts - s, 0);
		op(32'(SEC_OP_ARM), 8);
		op({16'h0, SEC_OP_STAT_WR, 8'hFF}, 16);
		chk(starts - s, 1);
		status_read_instruction(8'h03);
		done();
		chk(status_o, 8'h8C);
		wprot_n = 1'b0;
		u_sec_host_model.tick(6);
		chk(hard_lock_mode, 1'b1);
		op(32'(SEC_OP_ARM), 8);
		op({16'h0, SEC_OP_STAT_WR, 8'h00}, 16);
		chk(starts - s, 1);
		chk(protect_size_o, 2'h3);
		wprot_n = 1'b1;
		wstat(8'h00);
		chk(status_o, 8'h00);
	endtask
	// refusals depend on protect size and address; 5FFFh sweeps all four sizes, then 6000h checks the quarter edge
	task automatic t_protect();
		for (int bp = 0; bp < 4; bp++) begin
			wstat(8'(bp << 2));
			s = starts;
			op(32'(SEC_OP_ARM), 8);
			op({SEC_OP_ARR_WR, 24'h5FFFA5}, 32);
			chk(starts - s, bp < 2);
			if (bp < 2) begin
				chk(cmd_o.addr, 16'h5FFF);
				chk(wr_data_o, 8'hA5);
				done();
			end
		end
		wstat(8'h04);
		s = starts;
		op(32'(SEC_OP_ARM), 8);
		op({SEC_OP_ARR_WR, 24'h6000A5}, 32);
		chk(starts - s, 0);
		wstat(8'h00);
	endtask
	// id page and array read decode, then a busy refusal and a refused engine run
	task automatic t_codes();
		for (int a = 0; a < 2; a++) begin
			s = starts;
			op(32'(SEC_OP_ARM), 8);
			op({SEC_OP_ID_WR, 8'(a << 2), 8'h00, 8'h33}, 32);
			chk(starts - s, 1);
			chk(last_cmd.id_write, a == 0);
			chk(last_cmd.id_lock, a == 1);
			done();
			u_sec_host_model.sel();
			u_sec_host_model.shift({SEC_OP_ID_RD, 8'(a << 2), 8'h00}, 24, rx);
			u_sec_host_model.tick(4);
			chk(cmd_o.id_read, a == 0);
			chk(cmd_o.id_lock_rd, a == 1);
			u_sec_host_model.desel();
		end
		u_sec_host_model.sel();
		u_sec_host_model.shift({SEC_OP_ARR_RD, 16'h1234}, 24, rx);
		u_sec_host_model.tick(4);
		chk(cmd_o.arr_read, 1'b1);
		chk(cmd_o.addr, 16'h1234);
		u_sec_host_model.desel();
		chk(cmd_o.arr_read, 1'b0);
		s = starts;
		op(32'(SEC_OP_ARM), 8);
		op({SEC_OP_ARR_WR, 24'h01005A}, 32);
		op(32'(SEC_OP_ARM), 8);
		op({SEC_OP_ARR_WR, 24'h02005A}, 32);
		chk(starts - s, 1);
		chk(last_cmd.addr, 16'h0100);
		status_read_instruction(8'h03);
		write_refused = 1'b1;
		u_sec_host_model.tick(1);
		write_refused = 1'b0;
		u_sec_host_model.tick(4);
		chk(status_o, 8'h02);
		op(32'(SEC_OP_DISARM), 8);
		chk(status_o, 8'h00);
	endtask
	task automatic t_unknown();
		u_sec_host_model.sel();
		u_sec_host_model.shift(32'hFF, 8, rx);
		u_sec_host_model.shift(32'(SEC_OP_ARM), 8, rx);
		chk(miso_oe_n, 1'b1);
		u_sec_host_model.desel();
		chk(status_o[1], 1'b0);
		op(32'(SEC_OP_ARM), 8);
		chk(status_o[1], 1'b1);
	endtask
	task automatic t_pause();
		u_sec_host_model.sel();
		u_sec_host_model.shift(32'(SEC_OP_STAT_RD), 8, rx);
		u_sec_host_model.pause(1'b0);
		chk(miso_oe_n, 1'b1);
		u_sec_host_model.pause(1'b1);
		u_sec_host_model.shift(32'h0, 8, rx);
		chk(rx, 8'h02);
		u_sec_host_model.desel();
		op(32'(SEC_OP_DISARM), 8);
		u_sec_host_model.sel();
		u_sec_host_model.shift(32'(SEC_OP_ARM), 8, rx);
		u_sec_host_model.pause(1'b0);
		u_sec_host_model.desel();
		u_sec_host_model.pause(1'b1);
		chk(status_o[1], 1'b0);
	endtask
	initial begin
		reset = 1'b1;
		wprot_n = 1'b1;
		write_done = 1'b0;
		write_refused = 1'b0;
		repeat (16) @(posedge core_clk);
		#1;
		reset = 1'b0;
		u_sec_host_model.tick(4);
		chk(status_o, 8'h00);
		chk(miso_oe_n, 1'b1);
		t_arm();
		t_stat_write();
		t_protect();
		t_codes();
		t_unknown();
		t_pause();
		finish_test();
	end
	// run needs well under ten thousand cycles
	initial begin
		repeat (50000) @(posedge core_clk);
		fail_count++;
		finish_test();
	end
endmodule

// ===== bench/sec_host_model.sv
// sec_host_model: spi host driving select, clock, data and pause
// assumes core_clk paces a 400 ns link clock, idle low
`timescale 1ns/10ps
module sec_host_model (
	input wire logic core_clk,
	input wire logic miso,
	output logic sel_n,
	output logic sclk,
	output logic mosi,
	output logic pause_n
);
	// ----
	// host tasks
	// ----
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		pause_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// msb first; read back mid high phase, well after the fall
	task automatic shift(input logic [31:0] d, input int n, output logic [7:0] rx);
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			tick(4);
			sclk = 1'b1;
			tick(2);
			rx = {rx[6:0], miso};
			tick(2);
			sclk = 1'b0;
		end
	endtask
	task automatic sel();
		sel_n = 1'b0;
		tick(4);
	endtask
	// released data line flips so a stale bit cannot pass
	task automatic desel();
		sel_n = 1'b1;
		mosi = ~mosi;
		tick(10);
	endtask
	// pause edges only with the clock low; clock wiggles while paused
	task automatic pause(input logic p);
		pause_n = p;
		tick(6);
		if (!p) begin
			repeat (2) begin
				sclk = 1'b1;
				mosi = ~mosi;
				tick(4);
				sclk = 1'b0;
				tick(4);
			end
		end
	endtask
endmodule

// ===== common/sec_pkg.sv
// sec_pkg: constants and carrier types for the eeprom spi command front end
// assumes a 20 MHz core clock sampling a slower spi link
// Behaviour
// R1: while paused, output floats and serial input and clock are ignored.
// R2: host pauses only while chip select is low.
// R3: deselect during pause resets protocol state, aborting the instruction.
// R4: pause starts when pause pin falls while serial clock is low.
// R5: pause ends when pause pin rises with clock low; shifting resumes.
// R6: memory or status write accepted only on whole multiple of eight clocks.
// R7: modifying instructions rejected unless the write arm latch is set.
// R8: latch clears on power-up, disarm, status write and memory write completion.
// R9: instruction executes only if deselect falls between last and next clock rise.
// R10: last bit is opcode bit eight or data byte bit eight; reads exempt.
// R11: protect bits pick none, upper quarter, upper half or whole array.
// R12: opcodes arm 06h, disarm 04h, status read 05h.
// R13: opcodes status write 01h, array read 03h, array write 02h.
// R14: unknown opcode deselects device until chip select cycles.
// R15: id page opcodes 83h/82h; address bit ten picks page or lock.
// R16: arm opcode then deselect sets the write arm latch, only way.
// R17: disarm opcode then deselect clears the write arm latch.
// R18: status readable anytime, repeated while chip select stays low.
// R19: busy flag is one during memory or status write cycles.
// R20: protect bits non-volatile, changed only by status write outside hard lock.
// R21: lock bit one with protect pin low refuses status writes.
// R22: host should poll busy flag before new instructions.
// R23: inputs sampled on clock rise, outputs shifted after clock fall.
// R24: deselected output floats; first instruction needs a chip select fall.
// R25: status bits six to four read zero; write leaves 6,5,4,1,0 alone.
// R26: status layout busy b0, latch b1, protect b3:2, lock b7.
package sec_pkg;
	localparam logic [7:0] SEC_OP_ARM = 8'h06;
	localparam logic [7:0] SEC_OP_DISARM = 8'h04;
	localparam logic [7:0] SEC_OP_STAT_RD = 8'h05;
	localparam logic [7:0] SEC_OP_STAT_WR = 8'h01;
	localparam logic [7:0] SEC_OP_ARR_RD = 8'h03;
	localparam logic [7:0] SEC_OP_ARR_WR = 8'h02;
	localparam logic [7:0] SEC_OP_ID_RD = 8'h83;
	localparam logic [7:0] SEC_OP_ID_WR = 8'h82;
	localparam int SEC_BIT_BUSY = 0;
	localparam int SEC_BIT_ARM = 1;
	localparam int SEC_BIT_BP_LO = 2;
	localparam int SEC_BIT_BP_HI = 3;
	localparam int SEC_BIT_LOCK = 7;
	localparam int SEC_ID_SEL_BIT = 10;
	localparam logic [2:0] SEC_NV_RESET = 3'h0;
	localparam logic [14:0] SEC_ADDR_QUARTER = 15'h6000;
	localparam logic [14:0] SEC_ADDR_HALF = 15'h4000;
	localparam logic [14:0] SEC_ADDR_TOP = 15'h7FFF;
	localparam logic [1:0] SEC_BP_NONE = 2'h0;
	localparam logic [1:0] SEC_BP_QUARTER = 2'h1;
	localparam logic [1:0] SEC_BP_HALF = 2'h2;
	localparam logic [1:0] SEC_SYNC_STAGES = 2'h2;

	typedef enum logic [6:0] {
		SEC_ST_IDLE = 7'h01,
		SEC_ST_OPCODE = 7'h02,
		SEC_ST_ADDR = 7'h04,
		SEC_ST_DATA = 7'h08,
		SEC_ST_STAT_OUT = 7'h10,
		SEC_ST_WAIT_DESEL = 7'h20,
		SEC_ST_IGNORE = 7'h40
	} sec_state_t;

	// raw spi pins as seen after the synchronisers
	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic mosi;
		logic pause_n;
		logic wprot_n;
	} sec_pins_t;

	// request to the write engine and array
	typedef struct packed {
		logic mem_write;
		logic stat_write;
		logic arr_read;
		logic id_read;
		logic id_write;
		logic id_lock_rd;
		logic id_lock;
		logic [15:0] addr;
	} sec_cmd_t;
endpackage

// ===== hw/sec_front.sv
// sec_front: spi command decode, write arm latch, status and protection
// assumes an external write engine reports completion and array data path
`timescale 1ns/10ps
module sec_front
	import sec_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic pause_n,
	input wire logic wprot_n,
	output logic miso_o,
	output logic miso_oe_n,
	input wire logic write_done,
	input wire logic write_refused,
	output logic wr_start,
	output sec_cmd_t cmd_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] status_o,
	output logic [1:0] protect_size_o,
	output logic hard_lock_mode
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	sec_pins_t pins_raw;
	sec_pins_t pins;

	assign pins_raw = '{sel_n: sel_n, sclk: sclk, mosi: mosi, pause_n: pause_n, wprot_n: wprot_n};

	sec_sync u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.pins_in(pins_raw),
		.pins_out(pins)
	);

	logic sclk_d_r;
	logic sel_d_r;
	logic pause_d_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sclk_d_r <= 1'b0;
			sel_d_r <= 1'b1;
			pause_d_r <= 1'b1;
		end else begin
			sclk_d_r <= pins.sclk;
			sel_d_r <= pins.sel_n;
			pause_d_r <= pins.pause_n;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;

	assign sclk_rise = pins.sclk & ~sclk_d_r;
	assign sclk_fall = ~pins.sclk & sclk_d_r;
	assign sel_fall = ~pins.sel_n & sel_d_r;
	assign sel_rise = pins.sel_n & ~sel_d_r;

	// ------------------------------------------------------------
	// pause condition
	// ------------------------------------------------------------
	logic paused_r;
	logic pause_pend_r;

	// a pause edge that lands while the clock is high waits for the clock to fall
	always_ff @(posedge core_clk) begin
		if (reset || pins.sel_n || pins.pause_n) begin
			pause_pend_r <= 1'b0;
		end else if (pause_d_r && pins.sclk) begin
			pause_pend_r <= 1'b1; // R4
		end else if (!pins.sclk) begin
			pause_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || pins.sel_n) begin
			paused_r <= 1'b0; // R3
		end else if (!pins.pause_n && (pause_d_r || pause_pend_r) && !pins.sclk) begin
			paused_r <= 1'b1; // R4
		end else if (pins.pause_n && !pins.sclk) begin
			paused_r <= 1'b0; // R5
		end
	end

	// edges are only honoured outside a pause
	logic bit_in;
	logic bit_out;

	assign bit_in = sclk_rise & ~paused_r & ~pins.sel_n; // R1 R23
	assign bit_out = sclk_fall & ~paused_r & ~pins.sel_n; // R23

	// ------------------------------------------------------------
	// non-volatile and volatile status bits
	// ------------------------------------------------------------
	logic busy_r;
	logic arm_r;
	logic [1:0] bp_r;
	logic lock_r;
	logic hard_lock;

	assign hard_lock = lock_r & ~pins.wprot_n; // R21
	assign hard_lock_mode = hard_lock;
	assign protect_size_o = bp_r;

	always_comb begin
		status_o = 8'h00; // R25
		status_o[SEC_BIT_BUSY] = busy_r;
		status_o[SEC_BIT_ARM] = arm_r;
		status_o[SEC_BIT_BP_HI:SEC_BIT_BP_LO] = bp_r; // R26
		status_o[SEC_BIT_LOCK] = lock_r;
	end

	// ------------------------------------------------------------
	// shift and decode
	// ------------------------------------------------------------
	sec_state_t state_r;
	logic armed_after_reset_r;
	logic [7:0] shift_r;
	logic [2:0] bitcnt_r;
	logic [7:0] opcode_r;
	logic [15:0] addr_r;
	logic [1:0] addr_bytes_r;
	logic [7:0] data_r;
	logic byte_done_r;
	logic has_data_r;
	logic [7:0] stat_snap_r;
	logic [7:0] shift_nxt;

	assign shift_nxt = {shift_r[6:0], pins.mosi};

	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == SEC_OP_ARM) || (op == SEC_OP_DISARM) || (op == SEC_OP_STAT_RD) ||
			(op == SEC_OP_STAT_WR) || (op == SEC_OP_ARR_RD) || (op == SEC_OP_ARR_WR) ||
			(op == SEC_OP_ID_RD) || (op == SEC_OP_ID_WR); // R12 R13 R15
	endfunction

	// ------------------------------------------------------------
	// power-up select qualification
	// ------------------------------------------------------------
	// synchronisers restart high, so a pin already low at reset looks like a fall;
	// only a deselect seen once they have refilled qualifies the next fall
	logic [1:0] settle_r;
	logic pins_valid;

	assign pins_valid = (settle_r == SEC_SYNC_STAGES + 2'h1);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			settle_r <= 2'h0;
		end else if (!pins_valid) begin
			settle_r <= settle_r + 2'h1;
		end
	end

	// a chip select fall is required before the first instruction
	always_ff @(posedge core_clk) begin
		if (reset) begin
			armed_after_reset_r <= 1'b0;
		end else if (pins_valid && pins.sel_n) begin
			armed_after_reset_r <= 1'b1; // R24
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= SEC_ST_IDLE;
			shift_r <= 8'h00;
			bitcnt_r <= 3'h0;
			opcode_r <= 8'h00;
			addr_r <= 16'h0000;
			addr_bytes_r <= 2'h0;
			data_r <= 8'h00;
			byte_done_r <= 1'b0;
			has_data_r <= 1'b0;
		end else if (pins.sel_n) begin
			state_r <= SEC_ST_IDLE; // R3
			bitcnt_r <= 3'h0;
			addr_bytes_r <= 2'h0;
			has_data_r <= 1'b0;
			byte_done_r <= 1'b0;
		end else if (sel_fall) begin
			state_r <= armed_after_reset_r ? SEC_ST_OPCODE : SEC_ST_IGNORE; // R24
			bitcnt_r <= 3'h0;
			byte_done_r <= 1'b0;
		end else if (bit_in) begin
			shift_r <= shift_nxt;
			bitcnt_r <= bitcnt_r + 3'h1;
			byte_done_r <= (bitcnt_r == 3'h7); // R6 R10
			case (state_r)
				SEC_ST_OPCODE: begin
					if (bitcnt_r == 3'h7) begin
						opcode_r <= shift_nxt;
						if (!op_known(shift_nxt)) begin
							state_r <= SEC_ST_IGNORE; // R14
						end else if (shift_nxt == SEC_OP_STAT_RD) begin
							state_r <= SEC_ST_STAT_OUT; // R18
						end else if (shift_nxt == SEC_OP_STAT_WR) begin
							state_r <= SEC_ST_DATA;
						end else if (shift_nxt == SEC_OP_ARM || shift_nxt == SEC_OP_DISARM) begin
							state_r <= SEC_ST_WAIT_DESEL; // R16 R17
						end else begin
							state_r <= SEC_ST_ADDR;
						end
					end
				end
				SEC_ST_ADDR: begin
					if (bitcnt_r == 3'h7) begin
						addr_r <= {addr_r[7:0], shift_nxt};
						addr_bytes_r <= addr_bytes_r + 2'h1;
						if (addr_bytes_r == 2'h1) begin
							state_r <= SEC_ST_DATA;
						end
					end
				end
				SEC_ST_DATA: begin
					if (bitcnt_r == 3'h7) begin
						data_r <= shift_nxt;
						has_data_r <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end else if (sclk_fall) begin
			byte_done_r <= byte_done_r;
		end
	end

	// ------------------------------------------------------------
	// execution at deselect
	// ------------------------------------------------------------
	logic exec_ok;
	logic is_mod;
	logic [14:0] prot_base;
	logic in_prot;
	logic id_sel;

	assign id_sel = addr_r[SEC_ID_SEL_BIT]; // R15
	// byte_done_r drops on the next rising edge, so this catches the window
	// a deselect while paused aborts the instruction instead of running it
	assign exec_ok = sel_rise && byte_done_r && (bitcnt_r == 3'h0) && !paused_r; // R9 R10 R6 R3
	assign is_mod = (opcode_r == SEC_OP_STAT_WR) || (opcode_r == SEC_OP_ARR_WR) || (opcode_r == SEC_OP_ID_WR);

	always_comb begin
		prot_base = SEC_ADDR_TOP;
		in_prot = 1'b0;
		if (bp_r == SEC_BP_NONE) begin
			in_prot = 1'b0; // R11
		end else if (bp_r == SEC_BP_QUARTER) begin
			in_prot = addr_r[14:0] >= SEC_ADDR_QUARTER;
		end else if (bp_r == SEC_BP_HALF) begin
			in_prot = addr_r[14:0] >= SEC_ADDR_HALF;
		end else begin
			in_prot = 1'b1;
		end
		prot_base = addr_r[14:0] & SEC_ADDR_TOP;
	end

	logic go_stat_wr;
	logic go_mem_wr;
	logic go_id_wr;

	assign go_stat_wr = exec_ok && !busy_r && opcode_r == SEC_OP_STAT_WR && has_data_r && arm_r && !hard_lock; // R7 R21
	assign go_mem_wr = exec_ok && !busy_r && opcode_r == SEC_OP_ARR_WR && has_data_r && arm_r && !in_prot; // R7 R11
	assign go_id_wr = exec_ok && !busy_r && opcode_r == SEC_OP_ID_WR && has_data_r && arm_r;

	logic pend_stat_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy_r <= 1'b0;
			pend_stat_r <= 1'b0;
		end else if (go_stat_wr || go_mem_wr || go_id_wr) begin
			busy_r <= 1'b1; // R19
			pend_stat_r <= go_stat_wr;
		end else if (write_done || write_refused) begin
			busy_r <= 1'b0;
			pend_stat_r <= 1'b0;
		end
	end

	// nv bits keep value over core reset only in the array; here they restart at the shipped value
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bp_r <= SEC_NV_RESET[1:0];
			lock_r <= SEC_NV_RESET[2];
		end else if (pend_stat_r && write_done) begin
			bp_r <= data_r[SEC_BIT_BP_HI:SEC_BIT_BP_LO]; // R20 R25
			lock_r <= data_r[SEC_BIT_LOCK];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			arm_r <= 1'b0; // R8
		end else if (exec_ok && opcode_r == SEC_OP_ARM && state_r == SEC_ST_WAIT_DESEL) begin
			arm_r <= 1'b1; // R16
		end else if (exec_ok && opcode_r == SEC_OP_DISARM && state_r == SEC_ST_WAIT_DESEL) begin
			arm_r <= 1'b0; // R17
		end else if (busy_r && write_done) begin
			arm_r <= 1'b0; // R8
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_start <= 1'b0;
			cmd_o <= '0;
			wr_data_o <= 8'h00;
		end else begin
			wr_start <= go_stat_wr | go_mem_wr | go_id_wr;
			wr_data_o <= data_r;
			cmd_o.mem_write <= go_mem_wr;
			cmd_o.stat_write <= go_stat_wr;
			cmd_o.id_write <= go_id_wr && !id_sel;
			cmd_o.id_lock <= go_id_wr && id_sel;
			cmd_o.arr_read <= state_r == SEC_ST_DATA && opcode_r == SEC_OP_ARR_RD && !busy_r;
			cmd_o.id_read <= state_r == SEC_ST_DATA && opcode_r == SEC_OP_ID_RD && !id_sel;
			cmd_o.id_lock_rd <= state_r == SEC_ST_DATA && opcode_r == SEC_OP_ID_RD && id_sel;
			cmd_o.addr <= {1'b0, prot_base};
		end
	end

	// ------------------------------------------------------------
	// serial output
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stat_snap_r <= 8'h00;
			miso_o <= 1'b0;
		end else if (bit_out && state_r == SEC_ST_STAT_OUT) begin
			// snapshot each byte so busy can change between repeats
			if (bitcnt_r == 3'h0) begin
				stat_snap_r <= {status_o[6:0], 1'b0};
				miso_o <= status_o[7]; // R18 R23
			end else begin
				stat_snap_r <= {stat_snap_r[6:0], 1'b0};
				miso_o <= stat_snap_r[7];
			end
		end
	end

	assign miso_oe_n = ~(state_r == SEC_ST_STAT_OUT) | paused_r | pins.sel_n; // R1 R24
endmodule

// ===== hw/sec_sync.sv
// sec_sync: two flip-flop synchroniser for the spi pin bundle
// assumes pins are asynchronous to core_clk
`timescale 1ns/10ps
module sec_sync
	import sec_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire sec_pins_t pins_in,
	output sec_pins_t pins_out
);
	sec_pins_t meta_r;

	// idle value: deselected, pause released, protect pin high
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_r <= '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0, pause_n: 1'b1, wprot_n: 1'b1};
			pins_out <= '{sel_n: 1'b1, sclk: 1'b0, mosi: 1'b0, pause_n: 1'b1, wprot_n: 1'b1};
		end else begin
			meta_r <= pins_in;
			pins_out <= meta_r;
		end
	end
endmodule
